/* rtl/sar3w_map.svh */
`ifndef SAR3W_MAP_SVH
`define SAR3W_MAP_SVH
// conversion time bounds in ns
`define SAR3W_TCONV_MIN_NS 500
`define SAR3W_TCONV_MAX_NS 930
// clock period in ns
`define SAR3W_CLK_NS 10
// result width and readout edge counts
`define SAR3W_RES_W 16
`define SAR3W_EDGES_PLAIN 5'h10
`define SAR3W_EDGES_BUSY 5'h11
`define SAR3W_CNT_W 7
`define SAR3W_EDGE_ONE 5'h01
`define SAR3W_EDGE_ZERO 5'h00
`define SAR3W_RES_ZERO 16'h0000
`endif

/* rtl/sar3w_pkg.sv */
package sar3w_pkg;
    // conversion sequencer states
    typedef enum logic [1:0] {
        SAR3W_IDLE,
        SAR3W_CONV,
        SAR3W_ACQ
    } sar3w_state_e;
    // operating mode latched at each start edge
    typedef enum logic {
        SAR3W_MODE_CS,
        SAR3W_MODE_CHAIN
    } sar3w_mode_e;
endpackage : sar3w_pkg

/* rtl/sar3w_readout.sv */
`timescale 1ns/1ps
`include "sar3w_map.svh"
module sar3w_readout
    import sar3w_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // host pins
    input wire logic CONV_START_SELECT,
    input wire logic DATA_IN,
    input wire logic SCLK,
    // analog core result and conversion-time spread
    input wire logic [15:0] CORE_RESULT,
    input wire logic [`SAR3W_CNT_W-1:0] CONV_EXTRA,
    // serial output pin, oe low drives
    output logic DOUT_O,
    output logic DOUT_OE_N,
    // status
    output logic CONVERTING,
    output logic POWER_DOWN,
    output logic CHAIN_MODE,
    output logic [15:0] RESULT
);

    // =========================================================
    // timing
    // =========================================================
    // least time rounds up, longest rounds down
    localparam int CONV_MIN_CYC = (`SAR3W_TCONV_MIN_NS + `SAR3W_CLK_NS - 1) / `SAR3W_CLK_NS;
    localparam int CONV_MAX_CYC = `SAR3W_TCONV_MAX_NS / `SAR3W_CLK_NS;
    localparam logic [`SAR3W_CNT_W-1:0] MIN_C = CONV_MIN_CYC[`SAR3W_CNT_W-1:0];
    localparam logic [`SAR3W_CNT_W-1:0] MAX_C = CONV_MAX_CYC[`SAR3W_CNT_W-1:0];

    // clamp a requested length into the legal window
    function automatic logic [`SAR3W_CNT_W-1:0] clamp_len(input logic [`SAR3W_CNT_W-1:0] x);
        logic [`SAR3W_CNT_W:0] s;
        s = {1'b0, MIN_C} + {1'b0, x};
        clamp_len = (s > {1'b0, MAX_C}) ? MAX_C : s[`SAR3W_CNT_W-1:0];
    endfunction : clamp_len

    // edge of a sampled pin against its previous sample; rising selects the direction
    function automatic logic pin_edge(input logic now_v, input logic was_v, input logic rising);
        pin_edge = rising ? (now_v & ~was_v) : (~now_v & was_v);
    endfunction : pin_edge

    // =========================================================
    // pin edge detection
    // =========================================================
    logic cs_d_r;
    logic sclk_d_r;
    sar3w_state_e state_r, state_nxt;
    logic chain_r;
    logic busy_r;
    logic drive_r;
    logic [15:0] shift_r;
    logic [15:0] result_r;
    logic [4:0] edges_r;
    logic [`SAR3W_CNT_W-1:0] cnt_r;
    logic [`SAR3W_CNT_W-1:0] len_r;

    // history resets low: a pin already high at release reads as a start
    wire cs_rise = pin_edge(CONV_START_SELECT, cs_d_r, 1'b1);
    wire cs_fall = pin_edge(CONV_START_SELECT, cs_d_r, 1'b0);
    wire sclk_fall = pin_edge(SCLK, sclk_d_r, 1'b0);
    // phase decode shared by the timer, the readout and the checks
    wire in_conv = (state_r == SAR3W_CONV);
    wire in_acq = (state_r == SAR3W_ACQ);
    // a rise mid conversion neither restarts nor stretches the timer
    wire conv_start = cs_rise && !in_conv;
    wire conv_done = in_conv && (cnt_r == len_r);
    wire [4:0] edge_lim = busy_r ? `SAR3W_EDGES_BUSY : `SAR3W_EDGES_PLAIN;
    wire last_edge = drive_r && sclk_fall && (edges_r + `SAR3W_EDGE_ONE == edge_lim);
    wire cs_read = in_acq && !busy_r && !chain_r && cs_fall
        && (edges_r == `SAR3W_EDGE_ZERO) && !drive_r;

    // =========================================================
    // sequencer
    // =========================================================
    // next state; a start edge wins in idle and mid acquisition, but is ignored mid conversion
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            SAR3W_IDLE: if (cs_rise) state_nxt = SAR3W_CONV;
            SAR3W_CONV: if (conv_done) state_nxt = SAR3W_ACQ;
            SAR3W_ACQ: if (cs_rise) state_nxt = SAR3W_CONV;
            default: state_nxt = SAR3W_IDLE;
        endcase
    end

    // edge history and state
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            cs_d_r <= 1'b0;
            sclk_d_r <= 1'b0;
            state_r <= SAR3W_IDLE;
        end
        else
        begin
            cs_d_r <= CONV_START_SELECT;
            sclk_d_r <= SCLK;
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            chain_r <= 1'b0;
        else if (cs_rise)
            chain_r <= ~DATA_IN;
    end

    // internal timer, length clamped to bounds
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            cnt_r <= '0;
            len_r <= MIN_C;
        end
        else if (conv_start)
        begin
            cnt_r <= `SAR3W_CNT_W'(1);
            len_r <= clamp_len(CONV_EXTRA);
        end
        else if (in_conv)
            cnt_r <= cnt_r + `SAR3W_CNT_W'(1);
    end

    // result captured only at conversion end
    always_ff @(posedge CLK)
    begin
        if (RST)
            result_r <= `SAR3W_RES_ZERO;
        else if (conv_done)
            result_r <= CORE_RESULT;
    end

    // =========================================================
    // serial readout
    // =========================================================
    // chain mode is outside this block: it never drives the output
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            drive_r <= 1'b0;
            busy_r <= 1'b0;
            shift_r <= `SAR3W_RES_ZERO;
            edges_r <= `SAR3W_EDGE_ZERO;
        end
        else if (cs_rise)
        begin
            drive_r <= 1'b0;
            busy_r <= 1'b0;
            edges_r <= `SAR3W_EDGE_ZERO;
        end
        else if (conv_done && !chain_r)
        begin
            // busy bit when start low, else stay released
            busy_r <= ~CONV_START_SELECT;
            drive_r <= ~CONV_START_SELECT;
            shift_r <= CORE_RESULT;
            edges_r <= `SAR3W_EDGE_ZERO;
        end
        else if (cs_read)
            drive_r <= 1'b1;
        else if (last_edge)
        begin
            drive_r <= 1'b0;
            edges_r <= edge_lim;
        end
        // shift on serial falls; frozen once released
        else if (drive_r && sclk_fall)
        begin
            edges_r <= edges_r + `SAR3W_EDGE_ONE;
            if (!(busy_r && edges_r == `SAR3W_EDGE_ZERO))
                shift_r <= {shift_r[14:0], 1'b0};
        end
    end

    // output bit: busy low first, then result MSB first
    wire dout_bit = (busy_r && edges_r == `SAR3W_EDGE_ZERO) ? 1'b0 : shift_r[15];

    // registered pin outputs; one cycle behind internal state
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            DOUT_O <= 1'b0;
            DOUT_OE_N <= 1'b1;
            CONVERTING <= 1'b0;
            POWER_DOWN <= 1'b0;
            CHAIN_MODE <= 1'b0;
            RESULT <= `SAR3W_RES_ZERO;
        end
        else
        begin
            DOUT_O <= dout_bit;
            DOUT_OE_N <= ~drive_r;
            CONVERTING <= (state_r == SAR3W_CONV);
            POWER_DOWN <= (state_r == SAR3W_ACQ);
            CHAIN_MODE <= chain_r;
            RESULT <= result_r;
        end
    end

    // =========================================================
    // checks
    // =========================================================
    // all checks share the one clock; reset masks them
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // conversion sequencing
    a_conv_bounds: assert property (conv_done |-> cnt_r >= MIN_C && cnt_r <= MAX_C)
        else $error("conversion length out of bounds");
    a_start_release: assert property (cs_rise |=> !drive_r ##1 DOUT_OE_N)
        else $error("output not released on start rise");
    a_conv_runs: assert property (in_conv && !conv_done |=> in_conv &&
        cnt_r == $past(cnt_r) + `SAR3W_CNT_W'(1))
        else $error("conversion restarted or aborted");
    a_conv_flag: assert property (in_conv |=> CONVERTING)
        else $error("converting flag missing");
    a_mode_latch: assert property (cs_rise |=> chain_r == !$past(DATA_IN))
        else $error("mode not taken from data input");
    a_result_gate: assert property (!conv_done |=> $stable(result_r))
        else $error("result changed outside conversion end");
    a_pd_acq: assert property (state_r == SAR3W_ACQ |=> POWER_DOWN)
        else $error("not powered down in acquisition");

    // readout framing
    a_no_busy: assert property (conv_done && CONV_START_SELECT |=> !drive_r)
        else $error("busy bit with start high");
    a_busy_low: assert property (conv_done && !CONV_START_SELECT && !chain_r
        |=> drive_r ##1 (!DOUT_OE_N && !DOUT_O))
        else $error("busy bit not driven low");
    a_busy_bit: assert property (drive_r && busy_r && edges_r == `SAR3W_EDGE_ZERO
        |=> !DOUT_O)
        else $error("busy bit not low");
    a_msb_first: assert property (cs_read |=> ##1
        (!DOUT_OE_N && DOUT_O == $past(shift_r[15], 2)))
        else $error("msb not driven on start fall");
    a_shift_step: assert property (drive_r && sclk_fall && !last_edge && !cs_rise
        && !(busy_r && edges_r == `SAR3W_EDGE_ZERO)
        |=> shift_r == {$past(shift_r[14:0]), 1'b0})
        else $error("result did not advance one bit");
    a_plain_end: assert property (last_edge && !busy_r |->
        edges_r == `SAR3W_EDGES_PLAIN - `SAR3W_EDGE_ONE)
        else $error("plain readout length wrong");
    a_busy_end: assert property (last_edge && busy_r |->
        edges_r == `SAR3W_EDGES_BUSY - `SAR3W_EDGE_ONE)
        else $error("busy readout length wrong");
    a_release_oe: assert property (last_edge |=> ##1 DOUT_OE_N)
        else $error("output still driven after last edge");

    // released output
    a_chain_quiet: assert property (chain_r |-> !drive_r)
        else $error("chain mode drives output");
    a_frozen: assert property (!drive_r && !conv_done && !cs_rise |=> $stable(shift_r))
        else $error("shift moved while released");
    a_sclk_ignored: assert property (!drive_r && !cs_rise && !conv_done
        |=> edges_r == $past(edges_r))
        else $error("edge count moved while released");

    c_plain_read: cover property (cs_read ##[1:400] (last_edge && !busy_r));
    c_busy_read: cover property (conv_done && !CONV_START_SELECT ##[1:400] (last_edge && busy_r));
    c_abort: cover property (drive_r && cs_rise);
    c_chain: cover property (conv_done && chain_r);
    c_mid_rise: cover property (in_conv && cs_rise);

endmodule : sar3w_readout

/* bench/sar3w_host.sv */
`timescale 1ns/1ps
// ========================================
// host side of the three-wire link
module sar3w_host
(
    // clock
    input wire logic clk,
    // pins to the converter
    output logic conv_start_select,
    output logic data_in,
    output logic sclk,
    // serial pin from the converter
    input wire logic dout_o,
    input wire logic dout_oe_n,
    // resolved serial line
    output logic line
);
    assign line = dout_oe_n ? 1'b1 : dout_o;
    initial
    begin
        conv_start_select = 1'b0;
        data_in = 1'b1;
        sclk = 1'b0;
    end
    // level set well inside minimum time
    task automatic start(input logic din, input logic busy);
        conv_start_select = 1'b0;
        @(negedge clk);
        data_in = din;
        conv_start_select = 1'b1;
        @(negedge clk);
        data_in = 1'b1;
        repeat (2) @(negedge clk);
        // brief deselect mid conversion, as when other parts are picked
        conv_start_select = 1'b0;
        repeat (2) @(negedge clk);
        conv_start_select = ~busy;
    endtask : start
    // select only past maximum time; n counts from the call of select
    task automatic select(input int n);
        repeat (n) @(negedge clk);
        conv_start_select = 1'b0;
        repeat (3) @(negedge clk);
    endtask : select
    // start high ends a read and begins the next conversion
    task automatic idle();
        conv_start_select = 1'b1;
    endtask : idle
    // latch each bit before its falling edge
    task automatic read(input int n, output logic [16:0] w, output logic rel);
        w = 17'h00000;
        for (int i = 0; i < n; i++)
        begin
            w[n-1-i] = line;
            sclk = 1'b1;
            repeat (2) @(negedge clk);
            sclk = 1'b0;
            repeat (3) @(negedge clk);
        end
        rel = line;
    endtask : read
endmodule : sar3w_host

/* bench/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
// ========================================
// readout bench
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] core = 16'h0000;
    logic [6:0] extra = 7'h00;
    wire cs, din, sclk, line;
    logic dout_o, oe_n, conv, pd, chain;
    logic [15:0] res;
    int bad_count = 0;
    int tests_run = 0;
    int n0, n1, n2;
    // 100 MHz clock
    always #5 clk = ~clk;
    sar3w_host host (.clk(clk), .conv_start_select(cs), .data_in(din), .sclk(sclk),
        .dout_o(dout_o), .dout_oe_n(oe_n), .line(line));
    sar3w_readout DUT (.CLK(clk), .RST(rst), .CONV_START_SELECT(cs), .DATA_IN(din),
        .SCLK(sclk), .CORE_RESULT(core), .CONV_EXTRA(extra), .DOUT_O(dout_o),
        .DOUT_OE_N(oe_n), .CONVERTING(conv), .POWER_DOWN(pd), .CHAIN_MODE(chain),
        .RESULT(res));
    task automatic end_sim();
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    // low strap picks chain mode, never drives, even with start low at the end
    task automatic t_chain();
        host.start(1'b0, 1'b1);
        repeat (100) @(negedge clk);
        `CHK(chain, 1'b1)
        `CHK(oe_n, 1'b1)
    endtask : t_chain
    // plain read, msb at select fall
    task automatic t_plain(input logic [15:0] v);
        logic [16:0] w;
        logic rel;
        core = v;
        host.start(1'b1, 1'b0);
        `CHK({conv, oe_n, pd}, 3'h6)
        repeat (90) @(negedge clk);
        `CHK({pd, oe_n, line}, 3'h7)
        host.select(5);
        `CHK({chain, pd, res}, {2'h1, v})
        `CHK(oe_n, 1'b0)
        host.read(16, w, rel);
        `CHK(w[15:0], v)
        `CHK(rel, 1'b1)
        host.read(1, w, rel);
        `CHK({w[0], rel}, 2'h3)
        host.idle();
        repeat (100) @(negedge clk);
    endtask : t_plain
    // busy bit then 16 bits, length varies
    task automatic t_busy(input logic [6:0] x, input logic [15:0] v, output int n);
        logic [16:0] w;
        logic rel;
        core = v;
        extra = x;
        host.start(1'b1, 1'b1);
        n = 0;
        while (line === 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        `CHK(pd, 1'b1)
        `CHK(oe_n, 1'b0)
        host.read(17, w, rel);
        `CHK(w, {1'b0, v})
        `CHK(rel, 1'b1)
        host.idle();
        repeat (100) @(negedge clk);
    endtask : t_busy
    // start rise cuts a read short and converts
    task automatic t_abort();
        logic [16:0] w;
        logic rel;
        core = 16'h5A5A;
        host.start(1'b1, 1'b0);
        host.select(95);
        host.read(4, w, rel);
        `CHK(w[3:0], 4'h5)
        host.idle();
        repeat (3) @(negedge clk);
        `CHK({oe_n, conv}, 2'h3)
        repeat (100) @(negedge clk);
    endtask : t_abort
    // main sequence
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_chain();
        t_plain(16'hA5C3);
        t_busy(7'h00, 16'h8001, n0);
        t_busy(7'h7F, 16'hFFFF, n1);
        t_busy(7'h10, 16'h0001, n2);
        // length follows spread, clamped at maximum
        `CHK(n1 - n0, 43)
        `CHK(n2 - n0, 16)
        `CHK(n0, 47)
        t_abort();
        end_sim();
    end
    // watchdog, run needs about 1500 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim();
    end
endmodule : testbench
